// >>> rtl/asm_cfg.svh
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

// register offsets on the device register page
`define ASM_OFS_PIN_SEL   8'h1d
`define ASM_OFS_CH1_CFG   8'h1e
`define ASM_OFS_CH2_CFG   8'h1f

// reset values
`define ASM_RST_PIN_SEL   8'h00
`define ASM_RST_CH1_CFG   8'h20
`define ASM_RST_CH2_CFG   8'h21

// per-channel configuration fields
`define ASM_CFG_EN_BIT    5
`define ASM_CFG_SLOT_MSB  4
`define ASM_CFG_SLOT_LSB  0
`define ASM_CFG_RSV_MSB   7
`define ASM_CFG_RSV_LSB   6

// frame geometry
`define ASM_HALF_SLOTS    16
`define ASM_TDM_SLOTS     32
`define ASM_POS_W         11

`endif

// >>> rtl/asm_pkg.sv
package asm_pkg;

	typedef enum logic [1:0] {
		ASM_FMT_TDM = 2'h0,
		ASM_FMT_I2S = 2'h1,
		ASM_FMT_LJ  = 2'h3
	} asm_fmt_t;

	typedef struct packed {
		logic [31:0] ch1;
		logic [31:0] ch2;
	} asm_sample_t;

	typedef struct packed {
		logic       en;
		logic [4:0] slot;
	} asm_chan_cfg_t;

	typedef struct packed {
		logic dout;
		logic oe;
	} asm_pin_t;

endpackage : asm_pkg

// >>> rtl/asm_buf.sv
`timescale 1ns/1ps

module asm_buf #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             push;
	logic             pop;

	assign push = in_valid & in_ready;
	assign pop  = out_valid & out_ready;

	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + CW'(1);
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - CW'(1);
		end
	end

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction : ptr_inc

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			cnt_r     <= cnt_nxt;
			// ready is a flop so the source sees an honest full flag
			in_ready  <= (cnt_nxt != CW'(DEPTH));
			out_valid <= (cnt_nxt != '0);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	assign out_data = mem_r[rd_ptr_r];

endmodule : asm_buf

// >>> rtl/asm_tx_map.sv
`timescale 1ns/1ps
`include "asm_cfg.svh"

// Summary of operation
// - per-channel bit picks primary or secondary pin
// - disabled channel 1 leaves its slot tri-stated
// - enabled channel 1 sends first converter sample
// - slot codes 0-15 map TDM/left slots
// - codes 16-31 map TDM high/right slots
// - channel 1 resets enabled in slot 0
// - channel 2 resets enabled in slot 1
// - reserved bits 7-6 read zero, write zero
// - unoccupied cycles drive zero or float, per policy
module asm_tx_map #(
	parameter int SLOT_BITS = 32,
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// register page access
	input  wire logic [7:0]          reg_addr,
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_wdata,
	output logic [7:0]               reg_rdata_r,
	// framing controls held elsewhere in the device
	input  wire asm_pkg::asm_fmt_t   frame_fmt,
	input  wire logic                unused_cycle_fill_policy,
	// converter sample stream
	input  wire logic                smp_valid,
	input  wire asm_pkg::asm_sample_t smp_data,
	output logic                     smp_ready,
	// serial port pins
	input  wire logic                bclk_pin,
	input  wire logic                fsync_pin,
	output logic                     primary_serial_out_r,
	output logic                     primary_serial_oe_r,
	output logic                     secondary_serial_out_pin_r,
	output logic                     secondary_serial_oe_r
);

	localparam int PW = `ASM_POS_W;
	localparam logic [PW-1:0] POS_MAX = {PW{1'b1}};

	// register state
	logic [7:0]              pin_select_r;
	asm_pkg::asm_chan_cfg_t  ch1_cfg_r;
	asm_pkg::asm_chan_cfg_t  ch2_cfg_r;

	// pin synchronisers
	logic                    bclk_s1_r;
	logic                    bclk_s2_r;
	logic                    bclk_d_r;
	logic                    fsync_s1_r;
	logic                    fsync_s2_r;
	logic                    bclk_rise;
	logic                    bclk_fall;

	// framing
	logic [2:0]              fs_hist_r;
	logic                    fr_now;
	logic                    fr_old;
	logic                    start_r;
	logic                    start_left_r;
	logic                    right_r;
	logic                    active_r;
	logic [PW-1:0]           pos_r;
	asm_pkg::asm_sample_t    frame_r;

	// buffer drain side
	logic                    buf_valid;
	asm_pkg::asm_sample_t    buf_data;
	logic                    buf_pop;

	// bit selection
	logic [5:0]              cur_code;
	logic [4:0]              bit_idx;
	logic                    ch1_bit;
	logic                    ch2_bit;
	asm_pkg::asm_pin_t       pin_nxt [2];

	function automatic asm_pkg::asm_chan_cfg_t cfg_decode(input logic [7:0] d);
		cfg_decode.en   = d[`ASM_CFG_EN_BIT];
		cfg_decode.slot = d[`ASM_CFG_SLOT_MSB:`ASM_CFG_SLOT_LSB];
	endfunction : cfg_decode

	function automatic logic [7:0] cfg_encode(input asm_pkg::asm_chan_cfg_t c);
		cfg_encode                                        = 8'h00;
		cfg_encode[`ASM_CFG_EN_BIT]                       = c.en;
		cfg_encode[`ASM_CFG_SLOT_MSB:`ASM_CFG_SLOT_LSB]   = c.slot;
	endfunction : cfg_encode

	// true when the channel's slot code is the current bit's slot on that pin
	function automatic logic chan_hits(input asm_pkg::asm_chan_cfg_t c, input logic sel,
		input logic pin, input logic [5:0] code);
		chan_hits = code[5] && (c.slot == code[4:0]) && (sel == pin);
	endfunction : chan_hits

	// register writes; reserved bits are never stored
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_select_r <= `ASM_RST_PIN_SEL;
			ch1_cfg_r    <= cfg_decode(`ASM_RST_CH1_CFG);
			ch2_cfg_r    <= cfg_decode(`ASM_RST_CH2_CFG);
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ASM_OFS_PIN_SEL: begin
					pin_select_r <= reg_wdata;
				end
				`ASM_OFS_CH1_CFG: begin
					ch1_cfg_r <= cfg_decode(reg_wdata);
				end
				`ASM_OFS_CH2_CFG: begin
					ch2_cfg_r <= cfg_decode(reg_wdata);
				end
				default: begin
				end
			endcase
		end
	end

	// read data registered; reserved bits and unmapped addresses read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= 8'h00;
		end else begin
			unique case (reg_addr)
				`ASM_OFS_PIN_SEL: reg_rdata_r <= pin_select_r;
				`ASM_OFS_CH1_CFG: reg_rdata_r <= cfg_encode(ch1_cfg_r);
				`ASM_OFS_CH2_CFG: reg_rdata_r <= cfg_encode(ch2_cfg_r);
				default:          reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// two-flop synchronisers for the pins, plus a third stage for edges
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bclk_s1_r  <= 1'b0;
			bclk_s2_r  <= 1'b0;
			bclk_d_r   <= 1'b0;
			fsync_s1_r <= 1'b0;
			fsync_s2_r <= 1'b0;
		end else begin
			bclk_s1_r  <= bclk_pin;
			bclk_s2_r  <= bclk_s1_r;
			bclk_d_r   <= bclk_s2_r;
			fsync_s1_r <= fsync_pin;
			fsync_s2_r <= fsync_s1_r;
		end
	end

	assign bclk_rise = bclk_s2_r & ~bclk_d_r;
	assign bclk_fall = ~bclk_s2_r & bclk_d_r;

	// i2s data lags the frame edge by one bit clock, so it looks one step back
	assign fr_now = (frame_fmt == asm_pkg::ASM_FMT_I2S) ? fs_hist_r[1] : fs_hist_r[0];
	assign fr_old = (frame_fmt == asm_pkg::ASM_FMT_I2S) ? fs_hist_r[2] : fs_hist_r[1];

	// frame sync is sampled on bit clock rise; the edge is acted on at the fall
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fs_hist_r    <= 3'h0;
			start_r      <= 1'b0;
			start_left_r <= 1'b0;
		end else if (bclk_rise) begin
			fs_hist_r <= {fs_hist_r[1:0], fsync_s2_r};
			if (frame_fmt == asm_pkg::ASM_FMT_TDM) begin
				start_r      <= fr_now & ~fr_old;
				start_left_r <= fr_now & ~fr_old;
			end else begin
				start_r      <= fr_now ^ fr_old;
				// left half: fsync high for left-justified, low for i2s
				start_left_r <= (fr_now ^ fr_old) &
					(fr_now == (frame_fmt == asm_pkg::ASM_FMT_LJ));
			end
		end
	end

	// bit position advances on each bit clock fall; it saturates past the frame
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pos_r    <= POS_MAX;
			right_r  <= 1'b0;
			active_r <= 1'b0;
		end else if (bclk_fall) begin
			if (start_r) begin
				pos_r    <= '0;
				right_r  <= ~start_left_r;
				active_r <= 1'b1;
			end else if (pos_r != POS_MAX) begin
				pos_r <= pos_r + PW'(1);
			end
		end
	end

	// a new sample pair is taken only at the start of a frame
	assign buf_pop = bclk_fall & start_r & start_left_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frame_r <= '0;
		end else if (buf_pop) begin
			// an underrun sends silence rather than repeating stale audio
			frame_r <= buf_valid ? buf_data : '0;
		end
	end

	asm_buf #(
		.WIDTH ($bits(asm_pkg::asm_sample_t)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (smp_valid),
		.in_data   (smp_data),
		.in_ready  (smp_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (buf_pop)
	);

	// slot code of the current bit: {valid, 5-bit slot number}
	always_comb begin
		logic [PW-1:0] slot_idx;
		slot_idx = pos_r / PW'(SLOT_BITS);
		bit_idx  = 5'((SLOT_BITS - 1) - int'(pos_r % PW'(SLOT_BITS)));
		cur_code = 6'h00;
		if (active_r) begin
			if (frame_fmt == asm_pkg::ASM_FMT_TDM) begin
				if (slot_idx < PW'(`ASM_TDM_SLOTS)) begin
					cur_code = {1'b1, slot_idx[4:0]};
				end
			end else if (slot_idx < PW'(`ASM_HALF_SLOTS)) begin
				// right half codes are the half slot plus sixteen
				cur_code = {1'b1, right_r, slot_idx[3:0]};
			end
		end
	end

	// slot width above 32 is not supported; the bit index wraps, so the extra leading bits repeat the low bits
	assign ch1_bit = frame_r.ch1[bit_idx];
	assign ch2_bit = frame_r.ch2[bit_idx];

	// two enabled channels on one slot are ORed; the host must not do that
	for (genvar p = 0; p < 2; p++) begin : g_pin
		always_comb begin
			logic h1;
			logic h2;
			h1 = chan_hits(ch1_cfg_r, pin_select_r[0], 1'(p), cur_code);
			h2 = chan_hits(ch2_cfg_r, pin_select_r[1], 1'(p), cur_code);
			if ((h1 && ch1_cfg_r.en) || (h2 && ch2_cfg_r.en)) begin
				pin_nxt[p].oe   = 1'b1;
				pin_nxt[p].dout = (h1 & ch1_cfg_r.en & ch1_bit) |
					(h2 & ch2_cfg_r.en & ch2_bit);
			end else if (h1 || h2) begin
				pin_nxt[p].oe   = 1'b0;
				pin_nxt[p].dout = 1'b0;
			end else begin
				pin_nxt[p].oe   = ~unused_cycle_fill_policy;
				pin_nxt[p].dout = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			primary_serial_out_r       <= 1'b0;
			primary_serial_oe_r        <= 1'b0;
			secondary_serial_out_pin_r <= 1'b0;
			secondary_serial_oe_r      <= 1'b0;
		end else begin
			primary_serial_out_r       <= pin_nxt[0].dout;
			primary_serial_oe_r        <= pin_nxt[0].oe;
			secondary_serial_out_pin_r <= pin_nxt[1].dout;
			secondary_serial_oe_r      <= pin_nxt[1].oe;
		end
	end

endmodule : asm_tx_map

// >>> dv/asm_tx_map_monitor.sv
`timescale 1ns/1ps
module asm_tx_map_monitor (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_r,
	// stream and pins
	input wire logic       unused_cycle_fill_policy,
	input wire logic       smp_valid,
	input wire logic       smp_ready,
	input wire logic       primary_serial_out_r,
	input wire logic       primary_serial_oe_r,
	input wire logic       secondary_serial_out_pin_r,
	input wire logic       secondary_serial_oe_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_SEL_RST: assert property ($fell(rst) && reg_addr == 8'h1d |=> reg_rdata_r == 8'h00)
		else $error("pin select reset value");
	AST_CH1_RST: assert property ($fell(rst) && reg_addr == 8'h1e |=> reg_rdata_r == 8'h20)
		else $error("ch1 reset value");
	AST_CH2_RST: assert property ($fell(rst) && reg_addr == 8'h1f |=> reg_rdata_r == 8'h21)
		else $error("ch2 reset value");
	AST_RSV_ZERO: assert property (reg_addr == 8'h1e || reg_addr == 8'h1f |=> reg_rdata_r[7:6] == 2'h0)
		else $error("reserved bits not zero");
	AST_SEL_WR: assert property (reg_wr && reg_addr == 8'h1d ##1 (reg_addr == 8'h1d && !reg_wr)[*2]
		|-> reg_rdata_r == $past(reg_wdata, 2)) else $error("pin select write lost");
	AST_CH1_WR: assert property (reg_wr && reg_addr == 8'h1e ##1 (reg_addr == 8'h1e && !reg_wr)[*2]
		|-> reg_rdata_r == {2'h0, $past(reg_wdata[5:0], 2)}) else $error("ch1 write wrong");
	AST_CH2_WR: assert property (reg_wr && reg_addr == 8'h1f ##1 (reg_addr == 8'h1f && !reg_wr)[*2]
		|-> reg_rdata_r == {2'h0, $past(reg_wdata[5:0], 2)}) else $error("ch2 write wrong");
	AST_IDLE_FILL: assert property ($fell(rst) |=> primary_serial_oe_r == !$past(unused_cycle_fill_policy)
		&& secondary_serial_oe_r == !$past(unused_cycle_fill_policy) && !primary_serial_out_r
		&& !secondary_serial_out_pin_r) else $error("idle pins ignore fill policy");
	cover property (smp_valid && smp_ready);
	cover property (primary_serial_oe_r && primary_serial_out_r);
	cover property (secondary_serial_oe_r && secondary_serial_out_pin_r);
endmodule : asm_tx_map_monitor

// >>> dv/asm_host_rx.sv
`timescale 1ns/1ps
module asm_host_rx (
	// link clocks toward the device
	output logic      bclk_pin,
	output logic      fsync_pin,
	// data pins from the device
	input  wire logic p_out,
	input  wire logic p_oe,
	input  wire logic s_out,
	input  wire logic s_oe
);
	logic [1:0] cap_p [0:131];
	logic [1:0] cap_s [0:131];
	initial begin
		bclk_pin = 1'b0;
		fsync_pin = 1'b0;
	end
	// bit clock stands still between frames; sampling late, at the fall, leaves the device a full bit
	task run_frame(input logic [1:0] fmt);
		#7;
		for (int k = 0; k < 132; k++) begin
			fsync_pin = (fmt == 2'h0) ? (k == 1) : ((k >= 1 && k <= 64) ^ (fmt == 2'h1));
			#100 bclk_pin = 1'b1;
			#100 bclk_pin = 1'b0;
			cap_p[k] = {p_oe, p_oe & p_out};
			cap_s[k] = {s_oe, s_oe & s_out};
		end
	endtask : run_frame
endmodule : asm_host_rx

// >>> dv/asm_tx_map_tb.sv
`timescale 1ns/1ps
module asm_tx_map_tb;
	logic                 ref_clk = 1'b0;
	logic                 rst = 1'b1;
	logic [7:0]           reg_addr = 8'h1e;
	logic                 reg_wr = 1'b0;
	logic [7:0]           reg_wdata = 8'h00;
	logic [7:0]           reg_rdata_r;
	asm_pkg::asm_fmt_t    frame_fmt = asm_pkg::ASM_FMT_TDM;
	logic                 fill = 1'b0;
	logic                 smp_valid = 1'b0;
	asm_pkg::asm_sample_t smp_data = '0;
	logic                 smp_ready, bclk, fsync, p_out, p_oe, s_out, s_oe;
	int                   failures = 0;
	int                   tests_run = 0;

	always #12.5 ref_clk = ~ref_clk;

	asm_tx_map i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata_r(reg_rdata_r), .frame_fmt(frame_fmt), .unused_cycle_fill_policy(fill), .smp_valid(smp_valid),
		.smp_data(smp_data), .smp_ready(smp_ready), .bclk_pin(bclk), .fsync_pin(fsync), .primary_serial_out_r(p_out),
		.primary_serial_oe_r(p_oe), .secondary_serial_out_pin_r(s_out), .secondary_serial_oe_r(s_oe));
	asm_host_rx i_host (.bclk_pin(bclk), .fsync_pin(fsync), .p_out(p_out), .p_oe(p_oe), .s_out(s_out), .s_oe(s_oe));

	task results;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task do_reset(input logic [7:0] a);
		@(negedge ref_clk);
		rst = 1'b1;
		reg_addr = a;
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask : do_reset

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		reg_addr = a;
		repeat (2) @(negedge ref_clk);
		chk(64'(reg_rdata_r), 64'(e));
	endtask : rd

	task push(input logic [63:0] s);
		int n;
		@(negedge ref_clk);
		smp_valid = 1'b1;
		smp_data = s;
		for (n = 0; n < 100 && smp_ready !== 1'b1; n++) @(negedge ref_clk);
		if (n == 100) begin
			failures++;
			results();
		end
		@(negedge ref_clk);
		smp_valid = 1'b0;
	endtask : push

	// expected {oe, data} of one bit cycle; j counts bit cycles from the frame start
	function logic [1:0] expv(input logic [1:0] fmt, input logic [7:0] c1, input logic [7:0] c2,
		input logic [7:0] sel, input logic fl, input logic [63:0] s, input logic pin, input int j);
		logic       hit;
		logic       dis;
		logic       dat;
		logic [4:0] code;
		logic [7:0] c;
		int         p;
		hit = 1'b0;
		dis = 1'b0;
		dat = 1'b0;
		p = (fmt != 2'h0) ? j % 64 : j;
		code = (fmt == 2'h0) ? 5'(p / 32) : {j >= 64, 4'(p / 32)};
		for (int ch = 0; ch < 2; ch++) begin
			c = (ch == 1) ? c2 : c1;
			if (sel[ch] == pin && c[4:0] == code) begin
				hit = hit | c[5];
				dis = dis | !c[5];
				dat = dat | (c[5] & s[63 - 32 * ch - p % 32]);
			end
		end
		return hit ? {1'b1, dat} : ((dis || fl) ? 2'b00 : 2'b10);
	endfunction : expv

	task do_frame(input logic [1:0] fmt, input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] sel,
		input logic fl, input logic [63:0] s);
		int d;
		wr(8'h1d, sel);
		wr(8'h1e, c1);
		wr(8'h1f, c2);
		@(negedge ref_clk);
		fill = fl;
		frame_fmt = asm_pkg::asm_fmt_t'(fmt);
		i_host.run_frame(fmt);
		// frame edge acts one bit clock after it is sampled, capture trails the pin by one bit
		d = (fmt == 2'h1) ? 4 : 3;
		for (int j = 0; j < 128; j++) begin
			chk(64'(i_host.cap_p[j + d]), 64'(expv(fmt, c1, c2, sel, fl, s, 1'b0, j)));
			chk(64'(i_host.cap_s[j + d]), 64'(expv(fmt, c1, c2, sel, fl, s, 1'b1, j)));
		end
	endtask : do_frame

	task test_regs;
		rd(8'h1e, 8'h20);
		rd(8'h1f, 8'h21);
		rd(8'h1d, 8'h00);
		wr(8'h1e, 8'hff);
		rd(8'h1e, 8'h3f);
		wr(8'h1f, 8'hc4);
		rd(8'h1f, 8'h04);
		wr(8'h1c, 8'h5a);
		wr(8'h1d, 8'ha5);
		rd(8'h1d, 8'ha5);
		do_reset(8'h1f);
		do_reset(8'h1d);
		rd(8'h1e, 8'h20);
		$display("test_regs done");
	endtask : test_regs

	task test_buf;
		push(64'ha5c3_0ff1_9e26_d4b7);
		push(64'h3c5a_e187_0b6d_f249);
		repeat (2) @(negedge ref_clk);
		chk(64'(smp_ready), 64'h0);
		$display("test_buf done");
	endtask : test_buf

	task test_frames;
		do_frame(2'h0, 8'h20, 8'h21, 8'h00, 1'b0, 64'ha5c3_0ff1_9e26_d4b7);
		do_frame(2'h0, 8'h20, 8'h01, 8'h01, 1'b1, 64'h3c5a_e187_0b6d_f249);
		push(64'h9669_1ee1_c33c_7bb7);
		do_frame(2'h1, 8'h10, 8'h21, 8'h02, 1'b0, 64'h9669_1ee1_c33c_7bb7);
		push(64'h5aa5_8181_f00f_2dd2);
		do_frame(2'h3, 8'h30, 8'h31, 8'h00, 1'b1, 64'h5aa5_8181_f00f_2dd2);
		do_frame(2'h0, 8'h20, 8'h21, 8'h00, 1'b0, 64'h0);
		$display("test_frames done");
	endtask : test_frames

	initial begin
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		test_regs();
		test_buf();
		test_frames();
		results();
	end
endmodule : asm_tx_map_tb

bind asm_tx_map asm_tx_map_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .unused_cycle_fill_policy(unused_cycle_fill_policy),
	.smp_valid(smp_valid), .smp_ready(smp_ready), .primary_serial_out_r(primary_serial_out_r),
	.primary_serial_oe_r(primary_serial_oe_r), .secondary_serial_out_pin_r(secondary_serial_out_pin_r),
	.secondary_serial_oe_r(secondary_serial_oe_r));
